// *** host_port_model.sv ***
// host computer parallel port model for the mode switch
`timescale 1ns/10ps
module host_port_model (
  input wire logic clk_sys,
  input wire port_switch_pkg::status_s status,
  input wire logic [7:0] dev_data,
  output port_switch_pkg::ctrl_s ctrl,
  output logic [7:0] host_data
);
  import port_switch_pkg::*;
  initial begin
    ctrl = CTRL_IDLE;
    host_data = 8'h00;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : hold
  // strobe held long enough to pass the pin filter
  task automatic put_byte(input logic [7:0] b);
    @(posedge clk_sys);
    host_data <= b;
    hold(2);
    ctrl.strobe_n <= 1'b0;
    hold(8);
    ctrl.strobe_n <= 1'b1;
    hold(8);
  endtask : put_byte
  task automatic leave();
    @(posedge clk_sys);
    ctrl.init_n <= 1'b0;
    hold(8);
    ctrl.init_n <= 1'b1;
    hold(8);
  endtask : leave
  // software or native strobes look the same at the pins
  task automatic bus_cycle(input logic adr, input logic wr,
      input logic [7:0] b, output logic ok, output logic [12:0] seen);
    int n;
    n = 0;
    @(posedge clk_sys);
    // released lines flip so stale data never reads as valid
    host_data <= wr ? b : ~host_data;
    ctrl.strobe_n <= ~wr;
    if (adr) ctrl.selin_n <= 1'b0;
    else ctrl.autofd_n <= 1'b0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (status.busy !== 1'b1 && n < 120);
    ok = status.busy === 1'b1;
    seen = {status, dev_data};
    ctrl <= CTRL_IDLE;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (status.busy !== 1'b0 && n < 60);
    ok = ok && status.busy === 1'b0;
  endtask : bus_cycle
endmodule : host_port_model

// *** parallel_port_mode_switch.sv ***
// host parallel port front end: pass-through or instrument bus mode
`timescale 1ns/10ps
// How it works
// - after reset all host traffic goes straight to the pass-through port
// - host writes a key sequence then a mode byte; device detects them and enters bus mode
// - host pulsing init low ends bus mode; forwarding resumes
// - in bus mode host cycles become accesses to the bus controller
// - nibble link returns read data four bits at a time on status lines
// - EPP style cycles: strobe, device raises wait, host releases
// - three link modes: nibble, 8-bit bidirectional, EPP
// - address strobe and data strobe tell address from data cycles
module parallel_port_mode_switch (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] hd_i,
  output logic [7:0] hd_o,
  output logic hd_oe_n,
  input wire port_switch_pkg::ctrl_s host_ctrl_i,
  output port_switch_pkg::status_s host_status_o,
  output logic [7:0] pt_data_o,
  output port_switch_pkg::ctrl_s pt_ctrl_o,
  input wire port_switch_pkg::status_s pt_status_i,
  output logic tlc_wr_valid,
  input wire logic tlc_wr_ready,
  output port_switch_pkg::tlc_word_s tlc_wr_data,
  output logic tlc_rd_req,
  output logic [7:0] tlc_rd_addr,
  input wire logic tlc_rd_valid,
  input wire logic [7:0] tlc_rd_data,
  output logic bus_mode_o,
  output port_switch_pkg::link_e link_mode_o
);
  import port_switch_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0][7:0] d_sync;
    logic [7:0] d_f;
    logic [2:0][3:0] c_sync;
    ctrl_s c_f;
    logic [2:0][4:0] s_sync;
    status_s s_f;
    st_e st;
    link_e link;
    logic [2:0] seq_idx;
    logic [7:0] addr;
    logic nib_hi;
    logic [7:0] rbyte;
    logic wait_ack;
    logic [7:0] hd_o;
    logic hd_drive;
    status_s host_st;
    logic [7:0] pt_d;
    ctrl_s pt_c;
  } state_s;

  state_s q, d;
  logic fall_wr;
  logic fifo_in_ready;
  logic fifo_in_valid;
  logic fifo_has_data;
  logic [3:0] nib;

  // ------------------------------------------------------------
  // write buffer toward the bus controller
  // ------------------------------------------------------------
  // a full buffer stalls the write state, so the host wait line
  // holds off the next strobe
  assign fifo_in_valid = (q.st == ST_WRITE);

  word_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) i_word_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({q.addr, q.d_f}),
    .out_valid(fifo_has_data),
    .out_ready(tlc_wr_ready),
    .out_data(tlc_wr_data)
  );

  assign tlc_wr_valid = fifo_has_data;
  // reads wait for queued writes so they never overtake them
  assign tlc_rd_req = (q.st == ST_READ) && !fifo_has_data;
  assign tlc_rd_addr = q.addr;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    d = q;
    nib = q.host_st[3:0];
    // three stages; a change counts when stages two and three agree
    d.d_sync = {q.d_sync[1:0], hd_i};
    d.c_sync = {q.c_sync[1:0], host_ctrl_i};
    d.s_sync = {q.s_sync[1:0], pt_status_i};
    if (q.d_sync[1] == q.d_sync[2]) begin
      d.d_f = q.d_sync[2];
    end
    if (q.c_sync[1] == q.c_sync[2]) begin
      d.c_f = q.c_sync[2];
    end
    if (q.s_sync[1] == q.s_sync[2]) begin
      d.s_f = q.s_sync[2];
    end
    fall_wr = q.c_f.strobe_n && !d.c_f.strobe_n;
    d.pt_c = CTRL_IDLE;

    case (q.st)
      ST_PASS: begin
        if (fall_wr) begin
          if (q.d_f == ENTRY_KEY[q.seq_idx[1:0]]) begin
            if (q.seq_idx == KEY_LAST) begin
              d.st = ST_MODE;
              d.seq_idx = '0;
            end else begin
              d.seq_idx = q.seq_idx + 3'h1;
            end
          end else if (q.d_f == ENTRY_KEY[0]) begin
            d.seq_idx = 3'h1;
          end else begin
            d.seq_idx = '0;
          end
        end
      end
      ST_MODE: begin
        if (fall_wr) begin
          d.st = ST_IDLE;
          case (q.d_f)
            MODE_NIBBLE: d.link = LINK_NIBBLE;
            MODE_BYTE: d.link = LINK_BYTE;
            MODE_EPP: d.link = LINK_EPP;
            default: d.st = ST_PASS;
          endcase
          d.nib_hi = 1'b0;
        end
      end
      ST_IDLE: begin
        if (!q.c_f.selin_n) begin
          if (!q.c_f.strobe_n) begin
            d.addr = q.d_f;
          end else begin
            d.hd_o = q.addr;
            d.hd_drive = (q.link != LINK_NIBBLE);
            nib = q.addr[3:0];
          end
          d.st = ST_ACK;
        end else if (!q.c_f.autofd_n) begin
          if (!q.c_f.strobe_n) begin
            d.st = ST_WRITE;
          end else if (q.link == LINK_NIBBLE && q.nib_hi) begin
            nib = q.rbyte[7:4];
            d.nib_hi = 1'b0;
            d.st = ST_ACK;
          end else begin
            d.st = ST_READ;
          end
        end
      end
      ST_WRITE: begin
        if (fifo_in_ready) begin
          d.st = ST_ACK;
        end
      end
      ST_READ: begin
        if (tlc_rd_req && tlc_rd_valid) begin
          d.rbyte = tlc_rd_data;
          if (q.link == LINK_NIBBLE) begin
            nib = tlc_rd_data[3:0];
            d.nib_hi = 1'b1;
          end else begin
            d.hd_o = tlc_rd_data;
            d.hd_drive = 1'b1;
          end
          d.st = ST_ACK;
        end
      end
      ST_ACK: begin
        // host releases both strobes to close the cycle
        if (q.c_f.selin_n && q.c_f.autofd_n) begin
          d.st = ST_IDLE;
          d.hd_drive = 1'b0;
        end
      end
      default: d.st = ST_PASS;
    endcase

    if (q.st != ST_PASS && q.st != ST_MODE && !q.c_f.init_n) begin
      d.st = ST_PASS;
      d.hd_drive = 1'b0;
      d.nib_hi = 1'b0;
    end

    d.wait_ack = (d.st == ST_ACK);
    if (d.st == ST_PASS || d.st == ST_MODE) begin
      d.pt_d = q.d_f;
      d.pt_c = q.c_f;
      d.host_st = q.s_f;
    end else begin
      d.host_st = {d.wait_ack, nib};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q <= '0;
      q.c_sync <= {3{CTRL_IDLE}};
      q.c_f <= CTRL_IDLE;
      q.s_sync <= {3{STATUS_IDLE}};
      q.s_f <= STATUS_IDLE;
      q.host_st <= STATUS_IDLE;
      q.pt_c <= CTRL_IDLE;
      q.addr <= ADDR_RST;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign hd_o = q.hd_o;
  assign hd_oe_n = !q.hd_drive;
  assign host_status_o = q.host_st;
  assign pt_data_o = q.pt_d;
  assign pt_ctrl_o = q.pt_c;
  assign bus_mode_o = (q.st != ST_PASS) && (q.st != ST_MODE);
  assign link_mode_o = q.link;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking

  a_reset_pass: assert property (
    !rst_n |=> !bus_mode_o && pt_ctrl_o == CTRL_IDLE)
    else $error("not in pass-through after reset");
  a_pass_forward: assert property (
    disable iff (!rst_n)
    !bus_mode_o && $past(!bus_mode_o) && $past(rst_n) |->
      pt_data_o == $past(q.d_f) && pt_ctrl_o == $past(q.c_f))
    else $error("pass-through data not forwarded");
  a_entry_key: assert property (
    disable iff (!rst_n)
    $rose(q.st == ST_MODE) |-> $past(q.seq_idx) == KEY_LAST)
    else $error("mode byte stage reached without full key");
  a_full_sequence: assert property (
    disable iff (!rst_n)
    $rose(bus_mode_o) |-> $past(q.st) == ST_MODE)
    else $error("bus mode entered without key and mode byte");
  a_exit_init: assert property (
    disable iff (!rst_n)
    bus_mode_o && !q.c_f.init_n |=> !bus_mode_o ##1 pt_data_o == $past(q.d_f))
    else $error("init did not return to pass-through");
  a_pt_idle: assert property (
    disable iff (!rst_n)
    bus_mode_o && $past(bus_mode_o) |-> pt_ctrl_o == CTRL_IDLE)
    else $error("pass-through port active in bus mode");
  a_write_ack: assert property (
    disable iff (!rst_n)
    q.st == ST_WRITE && fifo_in_ready && q.c_f.init_n |=>
      host_status_o.busy)
    else $error("accepted write not acknowledged");
  a_nibble_lines: assert property (
    disable iff (!rst_n)
    q.st == ST_READ && tlc_rd_req && tlc_rd_valid && q.c_f.init_n &&
      link_mode_o == LINK_NIBBLE |=>
      host_status_o[3:0] == $past(tlc_rd_data[3:0]) && hd_oe_n)
    else $error("nibble not on status lines");
  a_wait_release: assert property (
    disable iff (!rst_n)
    host_status_o.busy && bus_mode_o && q.c_f.selin_n && q.c_f.autofd_n &&
      q.c_f.init_n |=> !host_status_o.busy && hd_oe_n)
    else $error("wait not released after strobes");
  a_addr_latch: assert property (
    disable iff (!rst_n)
    q.st == ST_IDLE && !q.c_f.selin_n && !q.c_f.strobe_n && q.c_f.init_n
      |=> q.addr == $past(q.d_f) ##1 tlc_rd_addr == $past(q.d_f, 2))
    else $error("address strobe did not latch address");
  a_link_legal: assert property (
    disable iff (!rst_n)
    bus_mode_o |-> link_mode_o inside {LINK_NIBBLE, LINK_BYTE, LINK_EPP})
    else $error("illegal link mode");

  c_enter_bus: cover property (disable iff (!rst_n) $rose(bus_mode_o));
  c_nibble_hi: cover property (disable iff (!rst_n)
    q.st == ST_IDLE && q.nib_hi && !q.c_f.autofd_n);
  c_fifo_full: cover property (disable iff (!rst_n)
    q.st == ST_WRITE && !fifo_in_ready);

endmodule : parallel_port_mode_switch

// *** port_switch_pkg.sv ***
// constants and types shared by the parallel port mode switch
package port_switch_pkg;

  // ------------------------------------------------------------
  // entry sequence and mode bytes
  // ------------------------------------------------------------
  // key bytes written in order; [0] comes first
  localparam logic [3:0][7:0] ENTRY_KEY = {8'h5a, 8'h3c, 8'hc3, 8'ha5};
  localparam logic [2:0] KEY_LAST = 3'h3;
  localparam logic [7:0] MODE_NIBBLE = 8'h01;
  localparam logic [7:0] MODE_BYTE = 8'h02;
  localparam logic [7:0] MODE_EPP = 8'h03;

  // ------------------------------------------------------------
  // sizes and reset values
  // ------------------------------------------------------------
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 16;
  localparam logic [3:0] CTRL_IDLE = 4'hf;
  localparam logic [4:0] STATUS_IDLE = 5'h0b;
  localparam logic [7:0] ADDR_RST = 8'h00;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {LINK_NIBBLE, LINK_BYTE, LINK_EPP} link_e;

  typedef enum logic [2:0] {
    ST_PASS, ST_MODE, ST_IDLE, ST_WRITE, ST_READ, ST_ACK
  } st_e;

  // host control lines; in bus mode autofd is the data strobe,
  // selin the address strobe and strobe the write line
  typedef struct packed {
    logic strobe_n;
    logic autofd_n;
    logic selin_n;
    logic init_n;
  } ctrl_s;

  // status lines; the low four carry a returned nibble
  typedef struct packed {
    logic busy;
    logic ack_n;
    logic paper_end;
    logic select;
    logic error_n;
  } status_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } tlc_word_s;

endpackage : port_switch_pkg

// *** testbench.sv ***
// self-checking bench for the parallel port mode switch
`timescale 1ns/10ps
module testbench;
  import port_switch_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] hd_host, hd_o, hd_i, pt_data, tlc_rd_addr;
  logic hd_oe_n, tlc_wr_valid, tlc_rd_req, bus_mode, ok;
  logic tlc_wr_ready = 1'b1;
  logic tlc_rd_valid = 1'b1;
  logic [7:0] tlc_rd_data = 8'h9c;
  ctrl_s ctrl, pt_ctrl;
  status_s host_status, pt_status = STATUS_IDLE;
  tlc_word_s tlc_wr_data;
  link_e link_mode;
  logic [12:0] seen;
  tlc_word_s got_q[$];
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  assign hd_i = hd_oe_n ? hd_host : hd_o;
  always #25 clk_sys = ~clk_sys;
  parallel_port_mode_switch i_parallel_port_mode_switch (
    .clk_sys(clk_sys), .rst_n(rst_n), .hd_i(hd_i), .hd_o(hd_o),
    .hd_oe_n(hd_oe_n), .host_ctrl_i(ctrl), .host_status_o(host_status),
    .pt_data_o(pt_data), .pt_ctrl_o(pt_ctrl), .pt_status_i(pt_status),
    .tlc_wr_valid(tlc_wr_valid), .tlc_wr_ready(tlc_wr_ready),
    .tlc_wr_data(tlc_wr_data), .tlc_rd_req(tlc_rd_req),
    .tlc_rd_addr(tlc_rd_addr), .tlc_rd_valid(tlc_rd_valid),
    .tlc_rd_data(tlc_rd_data), .bus_mode_o(bus_mode),
    .link_mode_o(link_mode));
  host_port_model i_host_port_model (.clk_sys(clk_sys),
    .status(host_status), .dev_data(hd_o), .ctrl(ctrl),
    .host_data(hd_host));
  always @(posedge clk_sys) begin
    if (tlc_wr_valid && tlc_wr_ready) got_q.push_back(tlc_wr_data);
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task automatic enter(input logic [7:0] mode);
    for (int k = 0; k <= int'(KEY_LAST); k++)
      i_host_port_model.put_byte(ENTRY_KEY[k]);
    i_host_port_model.put_byte(mode);
    i_host_port_model.hold(4);
  endtask : enter
  task automatic wr2(input logic [7:0] a, input logic [7:0] d);
    i_host_port_model.bus_cycle(1'b1, 1'b1, a, ok, seen);
    chk("addr ok", 16'h1, {15'h0, ok});
    i_host_port_model.bus_cycle(1'b0, 1'b1, d, ok, seen);
    i_host_port_model.hold(4);
    chk("data ok", 16'h1, {15'h0, ok});
    chk("word", {a, d}, got_q.pop_back());
  endtask : wr2
  task automatic t_pass();
    @(posedge clk_sys);
    pt_status <= 5'h15;
    i_host_port_model.put_byte(8'h42);
    chk("pt data", 16'h42, {8'h0, pt_data});
    chk("status copy", 16'h15, {11'h0, host_status});
    for (int k = 0; k < 2; k++) i_host_port_model.put_byte(ENTRY_KEY[k]);
    i_host_port_model.put_byte(8'h00);
    i_host_port_model.put_byte(MODE_BYTE);
    chk("partial key", 16'h0, {15'h0, bus_mode});
    $display("test pass done");
  endtask : t_pass
  task automatic t_byte();
    logic [7:0] snap;
    enter(MODE_BYTE);
    chk("bus mode", 16'h1, {15'h0, bus_mode});
    chk("link", {14'h0, LINK_BYTE}, {14'h0, link_mode});
    chk("pt idle", {12'h0, CTRL_IDLE}, {12'h0, pt_ctrl});
    snap = pt_data;
    wr2(8'h12, 8'h34);
    @(posedge clk_sys);
    tlc_rd_valid <= 1'b0;
    fork
      i_host_port_model.bus_cycle(1'b0, 1'b0, 8'h00, ok, seen);
      begin
        i_host_port_model.hold(30);
        chk("rd req", 16'h1, {15'h0, tlc_rd_req});
        chk("rd wait", 16'h0, {15'h0, host_status.busy});
        tlc_rd_valid <= 1'b1;
      end
    join
    chk("byte read", 16'h19c, {7'h0, ok, seen[7:0]});
    chk("rd addr", 16'h12, {8'h0, tlc_rd_addr});
    chk("pt held", {8'h0, snap}, {8'h0, pt_data});
    $display("test byte done");
  endtask : t_byte
  task automatic t_fill();
    @(posedge clk_sys);
    tlc_wr_ready <= 1'b0;
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      i_host_port_model.bus_cycle(1'b0, 1'b1, 8'(i), ok, seen);
      chk("fill ok", 16'h1, {15'h0, ok});
    end
    fork
      i_host_port_model.bus_cycle(1'b0, 1'b1, 8'h10, ok, seen);
      begin
        i_host_port_model.hold(40);
        chk("full stall", 16'h0, {15'h0, host_status.busy});
        tlc_wr_ready <= 1'b1;
      end
    join
    i_host_port_model.hold(30);
    chk("stalled ok", 16'h1, {15'h0, ok});
    chk("drained", 16'h11, 16'(got_q.size()));
    for (int i = 0; i <= FIFO_DEPTH; i++)
      chk("order", {8'h12, 8'(i)}, got_q.pop_front());
    $display("test fill done");
  endtask : t_fill
  task automatic t_exit();
    i_host_port_model.leave();
    chk("left", 16'h0, {15'h0, bus_mode});
    i_host_port_model.put_byte(8'h77);
    chk("pt again", 16'h77, {8'h0, pt_data});
    $display("test exit done");
  endtask : t_exit
  task automatic t_nibble();
    @(posedge clk_sys);
    tlc_rd_data <= 8'ha6;
    enter(MODE_NIBBLE);
    chk("link", {14'h0, LINK_NIBBLE}, {14'h0, link_mode});
    i_host_port_model.bus_cycle(1'b0, 1'b0, 8'h00, ok, seen);
    chk("low nib", 16'h16, {11'h0, ok, seen[11:8]});
    i_host_port_model.bus_cycle(1'b0, 1'b0, 8'h00, ok, seen);
    chk("high nib", 16'h1a, {11'h0, ok, seen[11:8]});
    i_host_port_model.leave();
    enter(MODE_EPP);
    chk("link", {14'h0, LINK_EPP}, {14'h0, link_mode});
    wr2(8'h55, 8'h66);
    i_host_port_model.leave();
    chk("left", 16'h0, {15'h0, bus_mode});
    $display("test nibble epp done");
  endtask : t_nibble
  initial begin
    repeat (6) @(posedge clk_sys);
    chk("rst pt", {12'h0, CTRL_IDLE}, {12'h0, pt_ctrl});
    chk("rst st", {11'h0, STATUS_IDLE}, {11'h0, host_status});
    chk("rst oe", 16'h1, {15'h0, hd_oe_n});
    chk("rst mode", 16'h0, {15'h0, bus_mode});
    rst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    t_pass();
    t_byte();
    t_fill();
    t_exit();
    t_nibble();
    final_report();
  end
endmodule : testbench

// *** word_fifo.sv ***
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
  } fifo_s;

  fifo_s q, d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  // count is one bit wider than the pointers so a full buffer reads DEPTH
  assign in_ready = (q.count != (AW+1)'(DEPTH));
  assign out_valid = (q.count != '0);
  assign out_data = mem[q.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    d = q;
    if (push) begin
      d.wr = q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = q.rd + 1'b1;
    end
    d.count = q.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // storage carries no reset; only the pointers and count need one
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[q.wr] <= in_data;
    end
  end

endmodule : word_fifo
